//--- logic/lvgp_pkg.sv
// Package with register map, field positions, reset values and timing counts of the pin block
package lvgp_pkg;
    localparam int LVGP_PINS = 4;
    localparam int LVGP_DW = 24;
    localparam int LVGP_AW = 6;
    localparam logic [5:0] PIN0_CONTROL_IDX = 6'h21;
    localparam logic [5:0] PIN1_CONTROL_IDX = 6'h22;
    localparam logic [5:0] PIN2_CONTROL_IDX = 6'h23;
    localparam logic [5:0] PIN3_CONTROL_IDX = 6'h24;
    localparam int F_DIR = 0;
    localparam int F_DIN = 1;
    localparam int F_DOUT = 2;
    localparam int F_SCHMITT = 3;
    localparam int F_FILT_LO = 4;
    localparam int F_EDGE_LO = 6;
    localparam int F_KEEPER = 8;
    localparam int F_OPEN_DRAIN = 9;
    localparam int F_STRONG = 10;
    localparam int F_PULL_ON = 11;
    localparam int F_PULL_LO = 12;
    localparam int F_RATE_LO = 14;
    localparam int F_USED_TOP = 15;
    // Writable bits; 1 (sensed level) and 23:16 are read-only
    localparam logic [23:0] CTRL_WMASK = 24'h00FFFD;
    localparam logic [23:0] CTRL_RESET = 24'h003808;
    localparam int CLK_HZ = 10_000_000;
    localparam int FILTER_STEP_MS = 10;
    localparam int FILTER_STEP_CYC = CLK_HZ / 1000 * FILTER_STEP_MS;
    typedef enum logic [1:0] {
        LVGP_EDGE_NONE = 2'b00,
        LVGP_EDGE_FALL = 2'b01,
        LVGP_EDGE_RISE = 2'b10,
        LVGP_EDGE_BOTH = 2'b11
    } lvgp_edge_t;
endpackage

//--- logic/lvgp_pin_if.sv
// Interface carrying one pin's configuration and status between the register file and the pin filter
`timescale 1ns/1ps
interface lvgp_pin_if;
    logic [1:0] filt_sel;
    logic [1:0] edge_sel;
    logic raw_in;
    logic clean_in;
    logic edge_evt;
    modport ctrl (output filt_sel, output edge_sel, output raw_in, input clean_in, input edge_evt);
    modport filt (input filt_sel, input edge_sel, input raw_in, output clean_in, output edge_evt);
endinterface

//--- logic/lvgp_tick.sv
// Divider giving a one-cycle pulse each filter step
`timescale 1ns/1ps
module lvgp_tick
    import lvgp_pkg::*;
#(
    parameter int STEP_CYC = FILTER_STEP_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    output logic tick
);
    logic [31:0] cnt;
    wire last_step = (cnt == 32'(STEP_CYC - 1));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 32'h0;
        end else begin
            cnt <= last_step ? 32'h0 : cnt + 32'h1;
        end
    end

    assign tick = last_step;
endmodule

//--- logic/lvgp_filter.sv
// Debounce filter and edge detector for one pin
`timescale 1ns/1ps
module lvgp_filter
    import lvgp_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic tick,
    lvgp_pin_if.filt pin
);
    logic clean;
    logic [1:0] steps;
    logic evt;
    wire differs = (pin.raw_in != clean);
    wire no_filter = (pin.filt_sel == 2'b00);
    wire settled = tick && (steps + 2'd1 >= pin.filt_sel);
    wire take = differs && (no_filter || settled);
    wire next_clean = take ? pin.raw_in : clean;
    wire rise = take && pin.raw_in;
    wire fall = take && !pin.raw_in;

    // Stable interval counted in whole filter steps; any bounce restarts it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            steps <= 2'b00;
        end else if (!differs || take) begin
            steps <= 2'b00;
        end else if (tick) begin
            steps <= steps + 2'd1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            clean <= 1'b0;
            evt <= 1'b0;
        end else begin
            clean <= next_clean;
            evt <= (pin.edge_sel[0] && fall) || (pin.edge_sel[1] && rise);
        end
    end

    assign pin.clean_in = clean;
    assign pin.edge_evt = evt;
endmodule

//--- logic/lvgp_port.sv
// Four low-voltage general-purpose pins with their control registers
`timescale 1ns/1ps
module lvgp_port
    import lvgp_pkg::*;
#(
    parameter int STEP_CYC = FILTER_STEP_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [LVGP_AW-1:0] reg_addr,
    input wire logic [LVGP_DW-1:0] reg_wdata,
    output logic [LVGP_DW-1:0] reg_rdata,
    output logic reg_hit,
    input wire logic [LVGP_PINS-1:0] pin_in,
    output logic [LVGP_PINS-1:0] pin_out,
    output logic [LVGP_PINS-1:0] pin_oe,
    output logic [LVGP_PINS-1:0] schmitt_select,
    output logic [LVGP_PINS-1:0] level_keeper_on,
    output logic [LVGP_PINS-1:0] strong_drive_on,
    output logic [LVGP_PINS-1:0] pull_resistor_on,
    output logic [2*LVGP_PINS-1:0] pull_choice,
    output logic [2*LVGP_PINS-1:0] edge_rate,
    output logic [LVGP_PINS-1:0] pin_edge_event
);
    // Maps a register number to a pin index; valid flag in bit 2
    function automatic logic [2:0] pin_decode(input logic [LVGP_AW-1:0] a);
        logic [2:0] r;
        r = 3'b000;
        if (a == PIN0_CONTROL_IDX) begin
            r = 3'b100;
        end else if (a == PIN1_CONTROL_IDX) begin
            r = 3'b101;
        end else if (a == PIN2_CONTROL_IDX) begin
            r = 3'b110;
        end else if (a == PIN3_CONTROL_IDX) begin
            r = 3'b111;
        end
        return r;
    endfunction

    logic [LVGP_DW-1:0] ctrl [LVGP_PINS];
    logic [LVGP_DW-1:0] rdata;
    logic tick;
    logic [LVGP_PINS-1:0] sensed;
    logic [LVGP_PINS-1:0] evt;

    wire [2:0] dec = pin_decode(reg_addr);
    wire sel_ok = dec[2];
    wire [1:0] sel_idx = dec[1:0];

    lvgp_tick #(.STEP_CYC(STEP_CYC)) u_tick (
        .mclk(mclk),
        .arst_n(arst_n),
        .tick(tick)
    );

    for (genvar i = 0; i < LVGP_PINS; i++) begin : g_pin
        lvgp_pin_if pif ();
        wire is_out = ctrl[i][F_DIR];
        wire level = ctrl[i][F_DOUT];
        wire od = ctrl[i][F_OPEN_DRAIN];

        assign pif.filt_sel = ctrl[i][F_FILT_LO+1:F_FILT_LO];
        assign pif.edge_sel = ctrl[i][F_EDGE_LO+1:F_EDGE_LO];
        assign pif.raw_in = pin_in[i];

        lvgp_filter u_filt (
            .mclk(mclk),
            .arst_n(arst_n),
            .tick(tick),
            .pin(pif)
        );

        assign sensed[i] = pif.clean_in;
        assign evt[i] = pif.edge_evt;
        assign pin_out[i] = od ? 1'b0 : level;
        assign pin_oe[i] = is_out && !(od && level);
        assign schmitt_select[i] = ctrl[i][F_SCHMITT];
        assign level_keeper_on[i] = ctrl[i][F_KEEPER];
        assign strong_drive_on[i] = ctrl[i][F_STRONG];
        assign pull_resistor_on[i] = ctrl[i][F_PULL_ON];
        assign pull_choice[2*i+:2] = ctrl[i][F_PULL_LO+1:F_PULL_LO];
        assign edge_rate[2*i+:2] = ctrl[i][F_RATE_LO+1:F_RATE_LO];

        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                ctrl[i] <= CTRL_RESET;
            end else if (reg_wr && sel_ok && sel_idx == 2'(i)) begin
                ctrl[i] <= reg_wdata & CTRL_WMASK;
            end
        end
    end

    // Sensed level replaces the stored bit 1 on reads
    always_comb begin
        rdata = '0;
        if (sel_ok) begin
            rdata = ctrl[sel_idx] & CTRL_WMASK;
            rdata[F_DIN] = sensed[sel_idx];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
            pin_edge_event <= '0;
        end else begin
            reg_rdata <= reg_rd ? rdata : reg_rdata;
            pin_edge_event <= evt;
        end
    end

    assign reg_hit = sel_ok;
endmodule

//--- dv/lvgp_port_chk.sv
// Port assertions for the four-pin block
`timescale 1ns/1ps
module lvgp_port_chk (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic [23:0] reg_rdata,
    input wire logic reg_hit,
    input wire logic [3:0] pin_in,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] schmitt_select,
    input wire logic [3:0] pull_resistor_on,
    input wire logic [7:0] pull_choice,
    input wire logic [3:0] pin_edge_event
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire w0 = reg_wr && reg_addr == 6'h21;
    AST_HIT: assert property (reg_hit == (reg_addr >= 6'h21 && reg_addr <= 6'h24))
        else $error("bad hit");
    AST_OE: assert property (w0 |=> pin_oe[0] ==
        ($past(reg_wdata[0]) && !($past(reg_wdata[9]) && $past(reg_wdata[2])))) else $error("bad oe");
    AST_OUT: assert property (w0 && reg_wdata[0] |=>
        pin_out[0] == ($past(reg_wdata[2]) && !$past(reg_wdata[9]))) else $error("bad out");
    AST_SCH: assert property (reg_wr && reg_addr == 6'h22 |=> schmitt_select[1] == $past(reg_wdata[3]))
        else $error("bad schmitt");
    AST_PUL: assert property (reg_wr && reg_addr == 6'h23 |=>
        {pull_choice[5:4], pull_resistor_on[2]} == $past(reg_wdata[13:11])) else $error("bad pull");
    AST_TOP: assert property (reg_rd |=> reg_rdata[23:16] == 8'h00)
        else $error("bad top");
    AST_MISS: assert property (reg_rd && !reg_hit |=> reg_rdata == 24'h000000)
        else $error("bad miss");
    // A pin that held its level for the sampling cycle cannot give a second edge
    AST_EVT: assert property (pin_edge_event[1] && $past(pin_in[1]) == $past(pin_in[1], 2) |=>
        !pin_edge_event[1]) else $error("long event");
endmodule
bind lvgp_port lvgp_port_chk u_chk (.mclk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_hit, .pin_in, .pin_oe, .pin_out, .schmitt_select, .pull_resistor_on, .pull_choice, .pin_edge_event);

//--- dv/lvgp_pin_net.sv
// External pin nets with pull resistors and a bench driver
`timescale 1ns/1ps
module lvgp_pin_net (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pull_on,
    input wire logic [7:0] pull_choice,
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    output logic [3:0] level
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i]) level[i] = pin_out[i];
            else if (ext_en[i]) level[i] = ext_val[i];
            else if (pull_on[i]) level[i] = pull_choice[2*i+1];
            else level[i] = ~pin_out[i];
        end
    end
endmodule

//--- dv/lvgp_port_tb.sv
// Self-checking bench for the four-pin block
`timescale 1ns/1ps
module lvgp_port_tb;
    logic mclk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, reg_hit;
    logic [5:0] reg_addr = 6'h00;
    logic [23:0] reg_wdata = 24'h000000, reg_rdata;
    logic [3:0] lvl, pin_out, pin_oe, schm, pull_on, evt, ext_en = 4'h0, ext_val = 4'hF;
    logic [7:0] pull_choice, rate;
    logic [3:0] kpr, strg;
    int num_errors = 0, total_checks = 0, cyc = 0, evts = 0;
    initial forever #50 mclk = ~mclk;
    lvgp_port #(.STEP_CYC(20)) u_dut (.mclk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_hit, .pin_in(lvl), .pin_out, .pin_oe, .schmitt_select(schm), .level_keeper_on(kpr),
        .strong_drive_on(strg), .pull_resistor_on(pull_on), .pull_choice, .edge_rate(rate), .pin_edge_event(evt));
    lvgp_pin_net u_net (.pin_out, .pin_oe, .pull_on, .pull_choice, .ext_en, .ext_val, .level(lvl));
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(negedge mclk);
        {reg_wr, reg_addr, reg_wdata} = {1'h1, a, d};
        @(negedge mclk);
        reg_wr = 1'h0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [23:0] exp);
        @(negedge mclk);
        {reg_rd, reg_addr} = {1'h1, a};
        @(negedge mclk);
        reg_rd = 1'h0;
        chk(reg_rdata, exp);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (evt[1] === 1'h1) evts++;
        if (cyc == 3000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(negedge mclk);
        arst_n = 1'h1;
        for (int i = 0; i < 4; i++) rd(6'(33 + i), 24'h00380A);
        wr(6'h21, 24'hFFFFFF);
        rd(6'h21, 24'h00FFFF);
        chk(24'({pin_oe[0], lvl[0]}), 24'h000001);
        wr(6'h21, 24'hFFFFFB);
        chk(24'({pin_oe[0], pin_out[0]}), 24'h000002);
        wr(6'h21, 24'h000005);
        chk(24'({pin_oe[0], pin_out[0]}), 24'h000003);
        wr(6'h25, 24'h00FFFF);
        rd(6'h25, 24'h000000);
        rd(6'h22, 24'h00380A);
        // Distinct pattern on pin 3 so a swapped field shows up
        wr(6'h24, 24'h00A500);
        rd(6'h24, 24'h00A502);
        chk(24'({kpr[3], strg[3], pull_on[3], pull_choice[7:6], rate[7:6], schm[3]}), 24'h0000D4);
        ext_en = 4'h6;
        // Each edge mode sees one fall and one rise on pin 1
        for (int m = 0; m < 4; m++) begin
            wr(6'h22, 24'h003808 | 24'(m << 6));
            evts = 0;
            ext_val[1] = 1'h0;
            repeat (5) @(negedge mclk);
            ext_val[1] = 1'h1;
            repeat (5) @(negedge mclk);
            chk(24'(evts), 24'(m % 2 + m / 2));
        end
        wr(6'h23, 24'h003838);
        ext_val[2] = 1'h0;
        repeat (30) @(negedge mclk);
        rd(6'h23, 24'h00383A);
        repeat (40) @(negedge mclk);
        rd(6'h23, 24'h003838);
        // One-step filter takes the level within one divider period
        wr(6'h23, 24'h003818);
        ext_val[2] = 1'h1;
        repeat (25) @(negedge mclk);
        rd(6'h23, 24'h00381A);
        // Two-step filter holds the old level for at least one period
        wr(6'h23, 24'h003828);
        ext_val[2] = 1'h0;
        repeat (10) @(negedge mclk);
        rd(6'h23, 24'h00382A);
        repeat (30) @(negedge mclk);
        rd(6'h23, 24'h003828);
        // Mid-run reset brings the registers back to their defaults
        arst_n = 1'h0;
        repeat (2) @(negedge mclk);
        arst_n = 1'h1;
        rd(6'h21, 24'h00380A);
        rd(6'h24, 24'h00380A);
        wrap_up();
    end
endmodule
